// [inc/tcs_defs.vh]
`ifndef TCS_DEFS_VH
`define TCS_DEFS_VH

// ---------------------------------------------------------------
// Frame layout
// ---------------------------------------------------------------
`define TCS_WORD_BITS      5'd16
`define TCS_WRITE_BIT      15
`define TCS_PWRDN_BIT      2
`define TCS_TEMP_EN_BIT    1
`define TCS_CTRL_RESET     16'h0000
`define TCS_ALL_ONES       16'hFFFF
`define TCS_TEMP_ID        4'h8

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define TCS_CLK_NS         4
`define TCS_CONV_US        100
// Cycle counts sized to their registers: 100 us and 100 ns at 4 ns
`define TCS_CONV_CYC       16'h61A8
`define TCS_GUARD_NS       100
`define TCS_GUARD_CYC      5'h19

`endif

// [hw/tcs_temp_seq.v]
`timescale 1ns/1ps
`include "tcs_defs.vh"

// Notes on behaviour
// - Guard violation may spoil next conversion; temperature read stays intact.
// - While busy, one frame reads previous result, may write control register.
// - Later chip-select falls while busy still open a frame but start no conversion.
// - Each extra frame while busy shifts out all ones.
// - Chip-select high throughout busy keeps data output three-stated.
// - Write in first 16 clocks after busy rises sets next conversion config.
// - Early write setting power-down aborts conversion, enters power-down at edge 16.
// - Conversion spans several frames; result not expected within one frame.
// - Integration starts at chip-select fall, busy high until conversion ends.
// - Temperature measure and convert takes at most 100 microseconds.
// - Control write captured on first 16 clock falls only if leading bit one.
// - Each read word is four channel bits then twelve result bits.
module tcs_temp_seq #(
    parameter [15:0] CONV_CYC = `TCS_CONV_CYC
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Serial link pins
    input  wire        cs_n,
    input  wire        sclk,
    input  wire        din,
    output reg         dout_o,
    output reg         dout_oe_n,
    // Conversion data and status
    input  wire [11:0] temp_result,
    output reg         temp_conversion_busy,
    output reg         partial_powerdown_bit,
    output reg  [15:0] ctrl_q
);

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    wire        cs_sync;
    wire        sck_sync;
    wire        din_sync;
    reg         cs_d_q;
    reg         sck_d_q;

    // Idle levels: chip select and link clock park high
    tcs_sync2 #(
        .RST_VAL (1'b1)
    ) u_cs_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .d       (cs_n),
        .q       (cs_sync)
    );

    tcs_sync2 #(
        .RST_VAL (1'b1)
    ) u_sck_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .d       (sclk),
        .q       (sck_sync)
    );

    tcs_sync2 #(
        .RST_VAL (1'b0)
    ) u_din_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .d       (din),
        .q       (din_sync)
    );

    // Edge history resets to the idle level, so reset gives no false edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_d_q  <= 1'b1;
            sck_d_q <= 1'b1;
        end else begin
            cs_d_q  <= cs_sync;
            sck_d_q <= sck_sync;
        end
    end

    wire cs_fall  = cs_d_q & ~cs_sync;
    wire cs_rise  = ~cs_d_q & cs_sync;
    // Link clock edges count only inside a selected frame
    wire sck_fall = sck_d_q & ~sck_sync & ~cs_sync;

    // ---------------------------------------------------------------
    // Frame engine
    // ---------------------------------------------------------------
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_BUSY  = 3'b010;
    localparam [2:0] ST_GUARD = 3'b100;

    reg  [2:0]  st_q;
    reg  [15:0] conv_cnt_q;
    reg  [4:0]  guard_cnt_q;
    reg  [4:0]  bit_cnt_q;
    reg  [15:0] tx_q;
    reg  [15:0] rx_q;
    reg         in_frame_q;
    reg         read_done_q;
    reg         early_q;
    reg  [11:0] result_q;

    wire [15:0] rx_next   = {rx_q[14:0], din_sync};
    wire [15:0] temp_word = {`TCS_TEMP_ID, result_q};

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q                  <= ST_IDLE;
            conv_cnt_q            <= 16'h0000;
            guard_cnt_q           <= 5'd0;
            bit_cnt_q             <= 5'd0;
            tx_q                  <= 16'h0000;
            rx_q                  <= 16'h0000;
            in_frame_q            <= 1'b0;
            read_done_q           <= 1'b0;
            early_q               <= 1'b0;
            result_q              <= 12'h000;
            dout_o                <= 1'b0;
            dout_oe_n             <= 1'b1;
            temp_conversion_busy  <= 1'b0;
            partial_powerdown_bit <= 1'b0;
            ctrl_q                <= `TCS_CTRL_RESET;
        end else begin
            // Guard breach is not flagged; spacing is the host's duty
            if (st_q == ST_GUARD) begin
                guard_cnt_q <= guard_cnt_q - 5'd1;
                if (guard_cnt_q == 5'd1) begin
                    st_q <= ST_IDLE;
                end
            end

            if (cs_fall) begin
                bit_cnt_q  <= 5'd0;
                rx_q       <= 16'h0000;
                in_frame_q <= 1'b1;
                dout_oe_n  <= 1'b0;
                case (st_q)
                    ST_BUSY: begin
                        if (read_done_q) begin
                            tx_q   <= `TCS_ALL_ONES;
                            dout_o <= 1'b1;
                        end else begin
                            tx_q        <= temp_word;
                            dout_o      <= temp_word[15];
                            read_done_q <= 1'b1;
                        end
                    end
                    default: begin
                        // Guard breach only risks the next sample; word stays whole
                        tx_q   <= temp_word;
                        dout_o <= temp_word[15];
                        if (ctrl_q[`TCS_TEMP_EN_BIT] && !partial_powerdown_bit) begin
                            st_q                 <= ST_BUSY;
                            temp_conversion_busy <= 1'b1;
                            conv_cnt_q           <= CONV_CYC;
                            read_done_q          <= 1'b0;
                            early_q              <= 1'b1;
                        end
                    end
                endcase
            end else if (in_frame_q && sck_fall) begin
                tx_q      <= {tx_q[14:0], 1'b1};
                dout_o    <= tx_q[14];
                rx_q      <= rx_next;
                bit_cnt_q <= bit_cnt_q + 5'd1;
                if (bit_cnt_q == `TCS_WORD_BITS - 5'd1) begin
                    in_frame_q <= 1'b0;
                    dout_oe_n  <= 1'b1;
                    if (rx_next[`TCS_WRITE_BIT]) begin
                        ctrl_q                <= rx_next;
                        partial_powerdown_bit <= rx_next[`TCS_PWRDN_BIT];
                        if (st_q == ST_BUSY && early_q && rx_next[`TCS_PWRDN_BIT]) begin
                            st_q                 <= ST_IDLE;
                            temp_conversion_busy <= 1'b0;
                        end
                    end
                    early_q <= 1'b0;
                end
            end else if (cs_rise) begin
                // Short frame: drop the word, release the line
                in_frame_q <= 1'b0;
                dout_oe_n  <= 1'b1;
            end

            // Busy counter never stalls, so the wall-clock bound holds
            // even when the host keeps toggling chip select
            if (st_q == ST_BUSY) begin
                if (conv_cnt_q <= 16'h0001) begin
                    st_q                 <= ST_GUARD;
                    temp_conversion_busy <= 1'b0;
                    guard_cnt_q          <= `TCS_GUARD_CYC;
                    result_q             <= temp_result;
                end else begin
                    conv_cnt_q <= conv_cnt_q - 16'h0001;
                end
            end
            if (st_q == ST_BUSY && sck_fall && bit_cnt_q == `TCS_WORD_BITS - 5'd1) begin
                early_q <= 1'b0;
            end
        end
    end

endmodule // tcs_temp_seq

// ---------------------------------------------------------------
// Two-stage pin synchroniser
// ---------------------------------------------------------------
// Only the second stage is visible; the first may go metastable
module tcs_sync2 #(
    parameter [0:0] RST_VAL = 1'b0
) (
    // Clock and reset
    input  wire clk,
    input  wire rst_n,
    // Pin in, synchronised level out
    input  wire d,
    output reg  q
);

    reg         meta_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule // tcs_sync2

// [bench/tcs_host_model.sv]
`timescale 1ns/1ps
module tcs_host_model (
    // Clock and link
    input  wire        clk,
    output logic       cs_n,
    output logic       sclk,
    output logic       din,
    input  wire        dout
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        din  = 1'b0;
    end
    // Link clock parks high outside frames, 32 ns period inside
    task automatic xfer(input logic [15:0] wr, output logic [15:0] rd);
        cs_n = 1'b0;
        repeat (8) @(negedge clk);
        for (int i = 15; i >= 0; i--) begin
            din = wr[i];
            repeat (4) @(negedge clk);
            sclk = 1'b0;
            rd[i] = dout;
            repeat (4) @(negedge clk);
            sclk = 1'b1;
        end
        cs_n = 1'b1;
        din  = ~din;
        repeat (4) @(negedge clk);
    endtask
endmodule // tcs_host_model

// [bench/tcs_seq_assertions.sv]
`timescale 1ns/1ps
module tcs_seq_checker #(
    parameter [15:0] CONV_CYC = 16'h0190
) (
    input wire        clk,
    input wire        rst_n,
    input wire        cs_n,
    input wire        sclk,
    input wire        din,
    input wire        dout_o,
    input wire        dout_oe_n,
    input wire [11:0] temp_result,
    input wire        temp_conversion_busy,
    input wire        partial_powerdown_bit,
    input wire [15:0] ctrl_q
);
    logic [15:0] busy_cnt_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) busy_cnt_q <= 16'h0000;
        else busy_cnt_q <= temp_conversion_busy ? busy_cnt_q + 16'h0001 : 16'h0000;
    end
    a_idle_three_state: assert property (cs_n [*6] |-> dout_oe_n)
        else $error("data line driven with chip select idle");
    a_busy_at_frame: assert property ($rose(temp_conversion_busy) |-> !cs_n)
        else $error("busy rose outside a frame");
    a_busy_bounded: assert property (busy_cnt_q <= CONV_CYC)
        else $error("conversion ran too long");
    a_ctrl_write_bit: assert property (!$stable(ctrl_q) |-> ctrl_q[15])
        else $error("control changed without write bit");
    a_pwrdn_from_ctrl: assert property ($rose(partial_powerdown_bit) |-> ctrl_q[2])
        else $error("power-down set without control bit");
    a_pwrdn_aborts: assert property (
        $rose(partial_powerdown_bit) |-> ##[0:2] !temp_conversion_busy)
        else $error("power-down did not abort conversion");
    a_start_config: assert property (
        $rose(temp_conversion_busy) |-> ctrl_q[1] && !partial_powerdown_bit)
        else $error("bad start config");
    a_first_bit_one: assert property ($fell(dout_oe_n) |-> dout_o && !cs_n)
        else $error("first bit not one at frame start");
    cover property ($rose(temp_conversion_busy));
    cover property ($rose(partial_powerdown_bit));
    cover property ($fell(dout_oe_n) && temp_conversion_busy);
endmodule // tcs_seq_checker
bind tcs_temp_seq tcs_seq_checker #(.CONV_CYC(CONV_CYC)) u_chk (.clk(clk), .rst_n(rst_n),
    .cs_n(cs_n), .sclk(sclk), .din(din), .dout_o(dout_o), .dout_oe_n(dout_oe_n),
    .temp_result(temp_result), .temp_conversion_busy(temp_conversion_busy),
    .partial_powerdown_bit(partial_powerdown_bit), .ctrl_q(ctrl_q));

// [bench/tcs_temp_seq_tb_top.sv]
`timescale 1ns/1ps
module tcs_temp_seq_tb_top;
    localparam [15:0] CONV = 16'h01F0;
    logic        clk;
    logic        rst_n;
    logic [11:0] temp_result;
    logic [15:0] rd;
    wire         cs_n, sclk, din, dout_o, dout_oe_n;
    wire         temp_conversion_busy, partial_powerdown_bit;
    wire  [15:0] ctrl_q;
    wire         dout_line = dout_oe_n ? 1'bz : dout_o;
    integer      err_total = 0;
    integer      total_checks = 0;
    tcs_temp_seq #(.CONV_CYC(CONV)) DUT (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
        .din(din), .dout_o(dout_o), .dout_oe_n(dout_oe_n), .temp_result(temp_result),
        .temp_conversion_busy(temp_conversion_busy),
        .partial_powerdown_bit(partial_powerdown_bit), .ctrl_q(ctrl_q));
    tcs_host_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout_line));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic test_config();
        chk({15'h0000, dout_oe_n}, 16'h0001);
        host.xfer(16'h8002, rd);
        chk(ctrl_q, 16'h8002);
        $display("test_config done");
    endtask
    task automatic test_busy_frames();
        host.xfer(16'h0000, rd);
        chk({12'h000, rd[15:12]}, 16'h0008);
        chk({15'h0000, temp_conversion_busy}, 16'h0001);
        host.xfer(16'h0000, rd);
        chk(rd, 16'h8000);
        host.xfer(16'h0000, rd);
        chk(rd, 16'hFFFF);
        chk(ctrl_q, 16'h8002);
        chk({15'h0000, temp_conversion_busy}, 16'h0001);
        for (int n = 0; n < 500 && temp_conversion_busy === 1'b1; n++) @(negedge clk);
        chk({15'h0000, temp_conversion_busy}, 16'h0000);
        chk({15'h0000, dout_oe_n}, 16'h0001);
        $display("test_busy_frames done");
    endtask
    // No guard wait on purpose: result must survive, power-down write aborts the new run
    task automatic test_breach_ppd();
        host.xfer(16'h8006, rd);
        chk(rd, 16'h8ABC);
        chk({15'h0000, temp_conversion_busy}, 16'h0000);
        chk({15'h0000, partial_powerdown_bit}, 16'h0001);
        chk(ctrl_q, 16'h8006);
        $display("test_breach_ppd done");
    endtask
    task automatic test_wake();
        repeat (26) @(negedge clk);
        host.xfer(16'h8002, rd);
        chk(rd, 16'h8ABC);
        chk({15'h0000, partial_powerdown_bit}, 16'h0000);
        chk({15'h0000, temp_conversion_busy}, 16'h0000);
        $display("test_wake done");
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #20000;
        err_total++;
        test_done();
    end
    initial begin
        rst_n = 1'b0;
        temp_result = 12'hABC;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        test_config();
        test_busy_frames();
        test_breach_ppd();
        test_wake();
        test_done();
    end
endmodule // tcs_temp_seq_tb_top
